// ### pkg/spi_pass_pkg.sv
package spi_pass_pkg;

  // Register offsets on the 8-bit register port.
  localparam logic [7:0] ADDR_DATA_TIMING = 8'h60;
  localparam logic [7:0] ADDR_SELECT_TIMING = 8'h61;
  localparam logic [7:0] ADDR_FORMAT_CONFIG = 8'h62;
  localparam logic [7:0] ADDR_ENGINE_STATUS = 8'h63;

  // Field positions.
  localparam int HOLD_MSB = 7;
  localparam int HOLD_LSB = 4;
  localparam int SETUP_MSB = 3;
  localparam int SETUP_LSB = 0;
  localparam int SS_SETUP_MSB = 3;
  localparam int SS_SETUP_LSB = 0;
  localparam int PHASE_BIT = 1;
  localparam int POLARITY_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_SELECT_BIT = 1;

  // Reset values.
  localparam logic [3:0] HOLD_RESET = 4'h2;
  localparam logic [3:0] SETUP_RESET = 4'h2;
  localparam logic [3:0] SS_SETUP_RESET = 4'h0;
  localparam logic POLARITY_RESET = 1'b0;
  localparam logic PHASE_VALUE = 1'b0;

  // Timing: all programmable delays are counted in 40 ns units.
  localparam int UNIT_NS = 40;
  localparam int MCLK_PERIOD_NS = 10;
  localparam int UNIT_CYCLES = (UNIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int PHASE_CNT_W = 7;

  // Serial frame size.
  localparam int BYTE_BITS = 8;

  // Engine states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SELECT = 3'b001,
    ST_SETUP = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_WAIT = 3'b100,
    ST_RELEASE = 3'b101
  } engine_state_type;

endpackage

// ### src/sync_two_flop.sv
`timescale 1ns/1ns
// Two-stage synchroniser; only the second stage is visible outside.
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage_one;

  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage_one <= '0;
      sync_o <= '0;
    end else begin
      stage_one <= async_i;
      sync_o <= stage_one;
    end
  end

endmodule

// ### src/spi_passthrough_timing_config.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ns
// Summary of operation
// - Data stays stable after the sampling edge for (hold field + 1) units of 40 ns.
// - Data is presented (setup field + 1) units of 40 ns before the active edge.
// - Each active clock phase lasts at least the hold field duration.
// - Each inactive clock phase lasts at least the setup field duration.
// - After select goes low, wait (select setup field + 1) units before data timing.
// - Phase bit is read-only zero; both ends sample on the leading clock edge.
// - Serial clock idles at the level of the polarity bit.
// - Polarity sets only the serial clock level; input capture and output data follow the clock phases.
module spi_passthrough_timing_config
  import spi_pass_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic link_tx_valid_i,
  input wire logic [7:0] link_tx_data_i,
  input wire logic link_tx_last_i,
  output logic link_tx_ready_o,
  output logic link_rx_valid_o,
  output logic [7:0] link_rx_data_o,
  output logic spi_sclk_o,
  output logic spi_ss_n_o,
  output logic spi_mosi_o,
  input wire logic spi_miso_i
);

  // Software-visible configuration.
  logic [3:0] hold_field;
  logic [3:0] setup_field;
  logic [3:0] ss_setup_field;
  logic clock_polarity_bit;

  // Link-domain handshake state.
  logic req_toggle;
  logic [7:0] req_data;
  logic req_last;
  logic ack_seen;
  logic ack_sync;

  // Core-domain engine state.
  engine_state_type state;
  logic [1:0] core_sync;
  logic req_sync;
  logic miso_sync;
  logic req_seen;
  logic ack_toggle;
  logic [PHASE_CNT_W-1:0] phase_cnt;
  logic [2:0] bit_cnt;
  logic [7:0] shift_out;
  logic [7:0] shift_in;
  logic [7:0] rx_byte;
  logic frame_last;
  logic frame_polarity;
  logic phase_done;
  logic new_request;

  // Converts a 4-bit field in 40 ns units into a terminal count of core cycles.
  function automatic logic [PHASE_CNT_W-1:0] phase_len(input logic [3:0] field);
    logic [PHASE_CNT_W-1:0] units;
    units = {3'h0, field} + 7'h01;
    return PHASE_CNT_W'(units * PHASE_CNT_W'(UNIT_CYCLES)) - 7'h01;
  endfunction

  // Register writes; the phase bit has no storage since it is fixed at zero.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_field <= HOLD_RESET;
      setup_field <= SETUP_RESET;
      ss_setup_field <= SS_SETUP_RESET;
      clock_polarity_bit <= POLARITY_RESET;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_DATA_TIMING: begin
          hold_field <= reg_wdata_i[HOLD_MSB:HOLD_LSB];
          setup_field <= reg_wdata_i[SETUP_MSB:SETUP_LSB];
        end
        ADDR_SELECT_TIMING: begin
          ss_setup_field <= reg_wdata_i[SS_SETUP_MSB:SS_SETUP_LSB];
        end
        ADDR_FORMAT_CONFIG: begin
          clock_polarity_bit <= reg_wdata_i[POLARITY_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data stands for exactly one cycle after the read strobe, zero otherwise.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_DATA_TIMING: begin
          reg_rdata_o <= {hold_field, setup_field};
        end
        ADDR_SELECT_TIMING: begin
          reg_rdata_o <= {4'h0, ss_setup_field};
        end
        ADDR_FORMAT_CONFIG: begin
          reg_rdata_o <= 8'h00;
          reg_rdata_o[PHASE_BIT] <= PHASE_VALUE;
          reg_rdata_o[POLARITY_BIT] <= clock_polarity_bit;
        end
        ADDR_ENGINE_STATUS: begin
          reg_rdata_o <= 8'h00;
          reg_rdata_o[STATUS_BUSY_BIT] <= (state != ST_IDLE);
          reg_rdata_o[STATUS_SELECT_BIT] <= ~spi_ss_n_o;
        end
        default: begin
          reg_rdata_o <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Link side: accept one byte, hold it stable and flip the request toggle.
  // The held byte is only read by the core after the toggle has crossed, so it never changes mid-crossing.
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_toggle <= 1'b0;
      req_data <= 8'h00;
      req_last <= 1'b0;
      link_tx_ready_o <= 1'b1;
    end else if (link_tx_valid_i && link_tx_ready_o) begin
      req_toggle <= ~req_toggle;
      req_data <= link_tx_data_i;
      req_last <= link_tx_last_i;
      link_tx_ready_o <= 1'b0;
    end else if (ack_sync != ack_seen) begin
      link_tx_ready_o <= 1'b1;
    end
  end

  // Link side: return the received byte once the acknowledge toggle arrives.
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_seen <= 1'b0;
      link_rx_valid_o <= 1'b0;
      link_rx_data_o <= 8'h00;
    end else begin
      link_rx_valid_o <= 1'b0;
      if (ack_sync != ack_seen) begin
        ack_seen <= ack_sync;
        link_rx_valid_o <= 1'b1;
        link_rx_data_o <= rx_byte;
      end
    end
  end

  // The acknowledge toggle crosses into the link domain.
  sync_two_flop #(
    .WIDTH(1)
  ) u_ack_sync (
    .clk_i(link_clk_i),
    .nrst_i(nrst_i),
    .async_i(ack_toggle),
    .sync_o(ack_sync)
  );

  // The request toggle and the data input pin cross into the core domain.
  sync_two_flop #(
    .WIDTH(2)
  ) u_core_sync (
    .clk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i({req_toggle, spi_miso_i}),
    .sync_o(core_sync)
  );

  assign req_sync = core_sync[1];
  assign miso_sync = core_sync[0];
  assign new_request = (req_sync != req_seen);
  assign phase_done = (phase_cnt == '0);

  // Engine sequencing: select delay, then per bit an inactive (setup) and an active (hold) phase.
  // Within a byte, data changes only when leaving the active phase, so the hold time is the whole active phase.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
      phase_cnt <= '0;
      bit_cnt <= 3'h0;
      req_seen <= 1'b0;
      frame_last <= 1'b0;
    end else begin
      if (!phase_done) begin
        phase_cnt <= phase_cnt - 7'h01;
      end
      case (state)
        ST_IDLE: begin
          if (new_request) begin
            req_seen <= req_sync;
            frame_last <= req_last;
            phase_cnt <= phase_len(ss_setup_field);
            state <= ST_SELECT;
          end
        end
        ST_SELECT: begin
          if (phase_done) begin
            bit_cnt <= 3'(BYTE_BITS - 1);
            phase_cnt <= phase_len(setup_field);
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (phase_done) begin
            phase_cnt <= phase_len(hold_field);
            state <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (phase_done) begin
            if (bit_cnt != 3'h0) begin
              bit_cnt <= bit_cnt - 3'h1;
              phase_cnt <= phase_len(setup_field);
              state <= ST_SETUP;
            end else if (frame_last) begin
              phase_cnt <= phase_len(setup_field);
              state <= ST_RELEASE;
            end else begin
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // Select stays low between bytes of one frame while the link supplies the next byte.
          if (new_request) begin
            req_seen <= req_sync;
            frame_last <= req_last;
            bit_cnt <= 3'(BYTE_BITS - 1);
            phase_cnt <= phase_len(setup_field);
            state <= ST_SETUP;
          end
        end
        ST_RELEASE: begin
          if (phase_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Slave select: low from the start of the select delay until the release phase ends.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spi_ss_n_o <= 1'b1;
    end else if (state == ST_IDLE && new_request) begin
      spi_ss_n_o <= 1'b0;
    end else if (state == ST_RELEASE && phase_done) begin
      spi_ss_n_o <= 1'b1;
    end
  end

  // Polarity is latched per frame so a register write cannot glitch the clock mid-transfer.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_polarity <= POLARITY_RESET;
    end else if (state == ST_IDLE) begin
      frame_polarity <= clock_polarity_bit;
    end
  end

  // Serial clock: idle level outside the active phase, inverted level during it.
  // While idle it follows the register directly, so a polarity change shows at once with select high.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spi_sclk_o <= POLARITY_RESET;
    end else if (state == ST_IDLE) begin
      spi_sclk_o <= clock_polarity_bit;
    end else if (state == ST_SETUP && phase_done) begin
      spi_sclk_o <= ~frame_polarity;
    end else if (state == ST_ACTIVE && phase_done) begin
      spi_sclk_o <= frame_polarity;
    end
  end

  // Output data: first bit placed at the start of the first setup phase, next bits after each trailing edge.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_out <= 8'h00;
      spi_mosi_o <= 1'b0;
    end else if (state == ST_IDLE && new_request) begin
      shift_out <= req_data;
    end else if (state == ST_WAIT && new_request) begin
      // A follow-on byte has no select delay, so its first bit must go out with the load itself.
      shift_out <= req_data;
      spi_mosi_o <= req_data[7];
    end else if (state == ST_SELECT && phase_done) begin
      spi_mosi_o <= shift_out[7];
    end else if (state == ST_ACTIVE && phase_done && bit_cnt != 3'h0) begin
      spi_mosi_o <= shift_out[6];
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

  // Input capture on the leading edge; the byte is handed to the link with the acknowledge toggle.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_in <= 8'h00;
      rx_byte <= 8'h00;
      ack_toggle <= 1'b0;
    end else if (state == ST_SETUP && phase_done) begin
      shift_in <= {shift_in[6:0], miso_sync};
    end else if (state == ST_ACTIVE && phase_done && bit_cnt == 3'h0) begin
      rx_byte <= shift_in;
      ack_toggle <= ~ack_toggle;
    end
  end

endmodule

// ### test/spi_timing_properties.sv
`timescale 1ns/1ns
// Watches the serial pins against the timing fields that software has written.
module spi_timing_properties (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic spi_sclk_o,
  input wire logic spi_ss_n_o,
  input wire logic spi_mosi_o
);
  logic [7:0] tim, sst, crun, mrun, lead, scnt;
  logic pol, idle, last_c, last_m;
  wire cchg = spi_sclk_o != last_c;
  wire lead_e = cchg && !spi_ss_n_o && spi_sclk_o != idle;
  wire [7:0] hold_n = (tim[7:4] + 8'h01) * 8'h04;
  wire [7:0] setup_n = (tim[3:0] + 8'h01) * 8'h04;
  wire [7:0] sel_n = (sst[3:0] + 8'h01) * 8'h04;

  // Shadow copies of the fields; the bench only reconfigures between frames.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tim <= 8'h22;
      sst <= 8'h00;
      pol <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'h60) tim <= reg_wdata_i;
      if (reg_addr_i == 8'h61) sst <= reg_wdata_i;
      if (reg_addr_i == 8'h62) pol <= reg_wdata_i[0];
    end
  end

  // Run lengths saturate so that a long idle spell cannot wrap into a short one.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_c <= 1'b0;
      last_m <= 1'b0;
      crun <= 8'hFF;
      mrun <= 8'hFF;
      lead <= 8'hFF;
      scnt <= 8'h00;
      idle <= 1'b0;
    end else begin
      last_c <= spi_sclk_o;
      last_m <= spi_mosi_o;
      crun <= cchg ? 8'h01 : crun + {7'h00, crun != 8'hFF};
      mrun <= (spi_mosi_o != last_m) ? 8'h01 : mrun + {7'h00, mrun != 8'hFF};
      lead <= spi_ss_n_o ? 8'hFF : lead_e ? 8'h01 : lead + {7'h00, lead != 8'hFF};
      scnt <= spi_ss_n_o ? 8'h00 : scnt + {7'h00, scnt != 8'hFF};
      if (spi_ss_n_o) idle <= spi_sclk_o;
    end
  end

  default clocking dck @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  sequence rd_tim;
    reg_rd_i && reg_addr_i == 8'h60;
  endsequence
  sequence rd_cfg;
    reg_rd_i && reg_addr_i == 8'h62;
  endsequence

  AST_HOLD_AFTER_LEAD: assert property ((spi_mosi_o != last_m) && !spi_ss_n_o |-> lead >= hold_n)
    else $error("data moved too soon after the sampling edge");
  AST_SETUP_BEFORE_LEAD: assert property (lead_e |-> mrun >= setup_n)
    else $error("data set up too late before the active edge");
  AST_ACTIVE_WIDTH: assert property (cchg && !spi_ss_n_o && spi_sclk_o == idle |-> crun >= hold_n)
    else $error("active clock phase too short");
  AST_INACTIVE_WIDTH: assert property (lead_e |-> crun >= setup_n)
    else $error("inactive clock phase too short");
  AST_SELECT_WAIT: assert property (lead_e |-> scnt >= sel_n)
    else $error("first edge too soon after select");
  AST_PHASE_ZERO: assert property (rd_cfg |=> reg_rdata_o[7:1] == 7'h00)
    else $error("phase or reserved bits read nonzero");
  AST_IDLE_LEVEL: assert property ($fell(spi_ss_n_o) |-> spi_sclk_o == pol)
    else $error("clock not at idle level at select");
  AST_QUIET_DESELECTED: assert property (spi_ss_n_o && cchg |-> spi_sclk_o == pol)
    else $error("clock toggled while deselected");
  AST_TIMING_READ: assert property (rd_tim |=> reg_rdata_o == $past(tim) ##1 reg_rdata_o == 8'h00)
    else $error("timing register read back wrong");
endmodule

// ### test/spi_slave_model.sv
`timescale 1ns/1ns
// Serial slave: takes mosi on the leading edge and repeats its reply byte MSB first.
module spi_slave_model (
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  input wire logic pol_i,
  input wire logic [7:0] reply_i,
  output logic miso_o,
  output logic [7:0] got_o
);
  logic [7:0] shift;
  initial miso_o = 1'b0;
  // First bit is presented as soon as select falls, since sampling is on the first edge.
  always @(negedge ss_n_i) begin
    shift = reply_i;
    miso_o = reply_i[7];
  end
  // A released line has no pull-up, so it shows the inverse of its last value.
  always @(posedge ss_n_i) miso_o = ~miso_o;
  // Leading edge leaves the idle level; the trailing edge moves the next bit out.
  always @(sclk_i) begin
    if (!ss_n_i && sclk_i != pol_i) got_o = {got_o[6:0], mosi_i};
    else if (!ss_n_i) begin
      shift = {shift[6:0], shift[7]};
      miso_o = shift[7];
    end
  end
endmodule

// ### test/spi_passthrough_timing_config_tb_top.sv
`timescale 1ns/1ns
module spi_passthrough_timing_config_tb_top;
  logic mclk = 1'b0, lclk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, tv = 1'b0, tl = 1'b0, pol = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, td = 8'h00, reply = 8'h96;
  wire [7:0] rdata, rxd, got;
  wire rxv, trdy, sclk, ssn, mosi, miso;
  int err_count = 0;
  int tests_run = 0;

  // The two clocks run at 10 ns and 12 ns, so crossings cycle through five alignments every 60 ns.
  always #5 mclk = ~mclk;
  always #6 lclk = ~lclk;

  spi_passthrough_timing_config dut (.mclk_i(mclk), .nrst_i(nrst), .link_clk_i(lclk), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .link_tx_valid_i(tv),
    .link_tx_data_i(td), .link_tx_last_i(tl), .link_tx_ready_o(trdy), .link_rx_valid_o(rxv),
    .link_rx_data_o(rxd), .spi_sclk_o(sclk), .spi_ss_n_o(ssn), .spi_mosi_o(mosi), .spi_miso_i(miso));
  spi_slave_model slave (.sclk_i(sclk), .ss_n_i(ssn), .mosi_i(mosi), .pol_i(pol), .reply_i(reply),
    .miso_o(miso), .got_o(got));

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the taking edge, so they are looked at there.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // One byte across the link; the offer is held until ready is seen at an edge.
  task automatic xfer(input logic [7:0] d, input logic l);
    int n;
    n = 0;
    @(posedge lclk);
    td <= d;
    tl <= l;
    tv <= 1'b1;
    do begin
      @(posedge lclk);
      n++;
    end while (trdy !== 1'b1 && n < 4000);
    tv <= 1'b0;
    do begin
      @(posedge lclk);
      n++;
    end while (rxv !== 1'b1 && n < 8000);
    if (n >= 8000) begin
      err_count++;
      $display("MISMATCH at %0t: link timed out", $time);
      finish_test();
    end else begin
      chk(rxd, reply);
    end
  endtask

  task automatic t_regs();
    rd_chk(8'h60, 8'h22);
    rd_chk(8'h61, 8'h00);
    rd_chk(8'h62, 8'h00);
    wr_reg(8'h61, 8'hFF);
    rd_chk(8'h61, 8'h0F);
    wr_reg(8'h62, 8'hFF);
    rd_chk(8'h62, 8'h01);
    wr_reg(8'h62, 8'h00);
    rd_chk(8'h64, 8'h00);
    rd_chk(8'h63, 8'h00);
    $display("test registers done");
  endtask
  // A reset in mid-run must bring the data timing and polarity fields and the serial pins back to their reset state.
  task automatic t_reset();
    @(posedge mclk);
    nrst <= 1'b0;
    pol = 1'b0;
    repeat (8) @(posedge mclk);
    chk({4'h0, trdy, ssn, sclk, mosi}, 8'h0C);
    nrst <= 1'b1;
    rd_chk(8'h60, 8'h22);
    rd_chk(8'h62, 8'h00);
    $display("test reset done");
  endtask
  // A two-byte frame: the first byte keeps select low, the second ends the frame.
  task automatic t_frame(input logic [7:0] t, input logic [7:0] s, input logic p);
    wr_reg(8'h60, t);
    wr_reg(8'h61, s);
    wr_reg(8'h62, {7'h00, p});
    pol = p;
    repeat (4) @(posedge mclk);
    chk({7'h00, sclk}, {7'h00, p});
    xfer(8'h3C, 1'b0);
    xfer(8'hC5, 1'b1);
    repeat (200) @(posedge mclk);
    chk({6'h00, ssn, sclk}, {6'h00, 1'b1, p});
    chk(got, 8'hC5);
    $display("test frame %h %h %b done", t, s, p);
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_frame(8'h22, 8'h00, 1'b0);
    t_frame(8'h11, 8'h0F, 1'b1);
    t_frame(8'hF1, 8'h03, 1'b0);
    t_frame(8'h1F, 8'h00, 1'b1);
    t_reset();
    finish_test();
  end
endmodule

bind spi_passthrough_timing_config spi_timing_properties u_props (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .spi_sclk_o(spi_sclk_o), .spi_ss_n_o(spi_ss_n_o), .spi_mosi_o(spi_mosi_o));
